// ---- core/fault_pkg.sv ----
// Purpose: constants shared by the fault supervision block
// Assumes: 40 MHz pclk, APB register access
// Notes: offsets are byte addresses of 32-bit words
package fault_pkg;
	localparam int NUM_FAULT = 32;
	localparam int NUM_WARN = 64;
	localparam int HIST_DEPTH = 16;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_FAULT_LATCH = 8'h08;
	localparam logic [7:0] OFS_WARN_LO = 8'h0C;
	localparam logic [7:0] OFS_WARN_HI = 8'h10;
	localparam logic [7:0] OFS_HIST_IDX = 8'h14;
	localparam logic [7:0] OFS_HIST_DATA = 8'h18;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
	localparam logic [7:0] OFS_DISP_MASK = 8'h24;
	localparam logic [7:0] OFS_FATAL_MASK = 8'h28;
	localparam logic [7:0] OFS_CMD_TIMEOUT = 8'h2C;
	localparam int CTRL_DISABLE = 0;
	localparam int CTRL_ENABLE = 1;
	localparam int CTRL_CLEAR_ALL = 2;
	localparam int CTRL_ALM_CFG = 3;
	localparam int CTRL_CMD_STROBE = 4;
	localparam int ST_ENABLED = 0;
	localparam int ST_READY = 1;
	localparam int ST_REMOTE = 2;
	localparam int ST_FATAL = 3;
	localparam int ST_ANY_FAULT = 4;
	localparam int IRQ_FAULT = 0;
	localparam int IRQ_WARN = 1;
	localparam int IRQ_FATAL = 2;
	localparam int CMD_LOST_WARN = 49;
	localparam logic [1:0] CMD_LOST_COUNT = 2'h3;
	localparam logic [31:0] FATAL_MASK_RST = 32'h00000000;
	localparam logic [31:0] DISP_MASK_RST = 32'hFFFFFFFF;
	localparam logic [7:0] DISP_BLANK = 8'h00;
	localparam logic [7:0] DISP_FAULT_BASE = 8'h80;
	localparam logic [7:0] DISP_WARN_BASE = 8'h40;
endpackage

// ---- core/toggle_detect.sv ----
// Purpose: recognise a deassert-then-reassert toggle of an enable source
// Assumes: input synchronous to pclk
// Notes: pulse comes on the reassertion edge
`timescale 1ns/10ps
module toggle_detect (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// source
	input wire logic level_in,
	input wire logic armed,
	// result
	output logic toggle_pulse
);
	logic prev_q;
	logic seen_low_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= level_in;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen_low_q <= 1'b0;
		end else if (!level_in && armed) begin
			seen_low_q <= 1'b1;
		end else if (level_in && !prev_q) begin
			seen_low_q <= 1'b0;
		end
	end

	// pulse only after a seen deassertion
	assign toggle_pulse = armed && seen_low_q && level_in && !prev_q;
endmodule

// ---- core/fault_history.sv ----
// Purpose: fault history store that keeps its content over power loss
// Assumes: array stands for the nonvolatile store; not cleared by reset
// Notes: circular, newest entry overwrites oldest
`timescale 1ns/10ps
module fault_history #(
	parameter int DEPTH = 16,
	parameter int AW = $clog2(DEPTH)
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// append side
	input wire logic wr_en,
	input wire logic [7:0] wr_code,
	// read side
	input wire logic [AW-1:0] rd_idx,
	output logic [7:0] rd_code,
	output logic [AW-1:0] wr_ptr,
	output logic [15:0] total
);
	logic [7:0] mem [DEPTH];
	logic [AW-1:0] ptr_q;
	logic [15:0] total_q;

	// nonvolatile array: no reset term on purpose
	always_ff @(posedge pclk) begin
		if (wr_en) begin
			mem[ptr_q] <= wr_code;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ptr_q <= '0;
			total_q <= 16'h0000;
		end else if (wr_en) begin
			ptr_q <= ptr_q + 1'b1;
			total_q <= total_q + 16'h0001;
		end
	end

	assign rd_code = mem[rd_idx];
	assign wr_ptr = ptr_q;
	assign total = total_q;
endmodule

// ---- core/drive_fault_latch_control.sv ----
// Purpose: latch drive faults, gate enable, track warnings, report status
// Assumes: condition inputs synchronous to pclk, APB slave registers
// Notes: zero-wait APB, pready always high
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps

// How it works
// - warnings are reported but never touch the drive enable
// - warning bits follow their conditions, no clear needed
// - any fault condition drops the enable at once and flags status
// - faults stay latched after the condition goes; enable refused meanwhile
// - a clear only drops latch bits whose condition is absent
// - disable command then enable command acts as a clear request
// - toggle of the remote enable line acts as a clear request
// - toggle on the alarm-clear input, when configured, clears faults
// - after clear with no condition the drive enables again
// - the lowest-numbered new fault of each cycle is appended to the persistent history
// - fatal faults stop the drive and block enabling until reset
// - clear-all command clears every latch whose condition is absent
// - latched faults and history contents are readable
// - ready flag high only when no latched fault blocks enabling
// - remote flag mirrors the hardware enable input
// - faults and masked-in warnings show as a display code
// - three missed target commands raise the command-lost warning
module drive_fault_latch_control
	import fault_pkg::*;
#(
	parameter int NF = NUM_FAULT,
	parameter int NW = NUM_WARN,
	parameter int HD = HIST_DEPTH
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// conditions
	input wire logic [NF-1:0] fault_cond,
	input wire logic [NW-1:0] warn_cond,
	input wire logic cmd_update,
	input wire logic cmd_received,
	// enable sources
	input wire logic remote_enable,
	input wire logic alarm_clear_in,
	// outputs
	output logic drive_enable,
	output logic [7:0] display_code,
	output logic irq
);
	localparam int HAW = $clog2(HD);

	// lowest set bit index, used for history and display
	function automatic logic [7:0] first_set(input logic [63:0] v);
		logic [7:0] r;
		r = 8'hFF;
		for (int i = 63; i >= 0; i--) begin
			if (v[i]) begin
				r = 8'(i);
			end
		end
		return r;
	endfunction

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [NF-1:0] fault_latch_q, fault_latch_d;
	logic [NF-1:0] fatal_mask_q, disp_mask_q;
	logic fatal_q;
	logic alm_cfg_q;
	logic host_en_q;
	logic host_disarm_q;
	logic drive_en_q;
	logic [NW-1:0] warn_q;
	logic [2:0] irq_stat_q, irq_mask_q, irq_evt;
	logic [HAW-1:0] hist_idx_q;
	logic [1:0] miss_cnt_q;
	logic [31:0] prdata_q, rd_mux;
	logic [7:0] disp_q;
	logic irq_q, err_q;

	logic wr_access;
	logic host_clear, remote_clear, alarm_clear, clear_req, clear_all;
	logic [NF-1:0] new_fault;
	logic [7:0] hist_code, hist_rd;
	logic [HAW-1:0] hist_wptr;
	logic [15:0] hist_total;
	logic [NW-1:0] warn_now;
	logic cmd_lost, rd_err;

	assign wr_access = psel && penable && pwrite;

	// ----------------------------------------
	// clear request sources
	// ----------------------------------------
	assign clear_all = wr_access && paddr == OFS_CTRL && pwdata[CTRL_CLEAR_ALL];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alm_cfg_q <= 1'b0;
			host_en_q <= 1'b1;
			host_disarm_q <= 1'b0;
		end else if (wr_access && paddr == OFS_CTRL) begin
			alm_cfg_q <= pwdata[CTRL_ALM_CFG];
			if (pwdata[CTRL_DISABLE]) begin
				host_en_q <= 1'b0;
				host_disarm_q <= 1'b1;
			end else if (pwdata[CTRL_ENABLE]) begin
				host_en_q <= 1'b1;
				host_disarm_q <= 1'b0;
			end
		end
	end
	// disable then enable counts as a clear
	assign host_clear = wr_access && paddr == OFS_CTRL && !pwdata[CTRL_DISABLE] && pwdata[CTRL_ENABLE]
		&& host_disarm_q;

	toggle_detect u_remote_tog (
		.pclk(pclk),
		.presetn(presetn),
		.level_in(remote_enable),
		.armed(1'b1),
		.toggle_pulse(remote_clear)
	);
	toggle_detect u_alarm_tog (
		.pclk(pclk),
		.presetn(presetn),
		.level_in(alarm_clear_in),
		.armed(alm_cfg_q),
		.toggle_pulse(alarm_clear)
	);

	assign clear_req = host_clear || remote_clear || alarm_clear || clear_all;

	// ----------------------------------------
	// fault latch
	// ----------------------------------------
	assign new_fault = fault_cond & ~fault_latch_q;
	always_comb begin
		fault_latch_d = fault_latch_q | fault_cond;
		if (clear_req) begin
			fault_latch_d = fault_cond;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_latch_q <= '0;
		end else begin
			fault_latch_q <= fault_latch_d;
		end
	end

	// fatal is sticky until power-on reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fatal_q <= 1'b0;
		end else if (|(fault_cond & fatal_mask_q)) begin
			fatal_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// drive enable
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drive_en_q <= 1'b0;
		end else if (fatal_q || |fault_cond || |fault_latch_q) begin
			drive_en_q <= 1'b0;
		end else begin
			drive_en_q <= host_en_q && remote_enable;
		end
	end

	// ----------------------------------------
	// warnings
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			miss_cnt_q <= 2'h0;
		end else if (cmd_update) begin
			if (cmd_received) begin
				miss_cnt_q <= 2'h0;
			end else if (miss_cnt_q != CMD_LOST_COUNT) begin
				miss_cnt_q <= miss_cnt_q + 2'h1;
			end
		end
	end
	assign cmd_lost = miss_cnt_q == CMD_LOST_COUNT;
	always_comb begin
		warn_now = warn_cond;
		warn_now[CMD_LOST_WARN] = warn_cond[CMD_LOST_WARN] | cmd_lost;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			warn_q <= '0;
		end else begin
			warn_q <= warn_now;
		end
	end

	// ----------------------------------------
	// history
	// ----------------------------------------
	assign hist_code = first_set(64'(new_fault));

	fault_history #(
		.DEPTH(HD)
	) u_hist (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(|new_fault),
		.wr_code(hist_code),
		.rd_idx(hist_idx_q),
		.rd_code(hist_rd),
		.wr_ptr(hist_wptr),
		.total(hist_total)
	);

	// ----------------------------------------
	// display
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			disp_q <= DISP_BLANK;
		end else if (|fault_latch_q) begin
			disp_q <= DISP_FAULT_BASE | first_set(64'(fault_latch_q));
		end else if (|(warn_q & 64'(disp_mask_q))) begin
			disp_q <= DISP_WARN_BASE | first_set(64'(warn_q & 64'(disp_mask_q)));
		end else begin
			disp_q <= DISP_BLANK;
		end
	end

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	assign irq_evt = {fatal_q, |(warn_now & ~warn_q), |new_fault};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_q <= 3'h0;
		end else if (wr_access && paddr == OFS_IRQ_STAT) begin
			irq_stat_q <= (irq_stat_q & ~pwdata[2:0]) | irq_evt;
		end else begin
			irq_stat_q <= irq_stat_q | irq_evt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(irq_stat_q & irq_mask_q);
		end
	end

	// ----------------------------------------
	// apb configuration writes
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_q <= 3'h0;
			disp_mask_q <= DISP_MASK_RST;
			fatal_mask_q <= FATAL_MASK_RST;
			hist_idx_q <= '0;
		end else if (wr_access) begin
			if (paddr == OFS_IRQ_MASK) begin
				irq_mask_q <= pwdata[2:0];
			end else if (paddr == OFS_DISP_MASK) begin
				disp_mask_q <= pwdata;
			end else if (paddr == OFS_FATAL_MASK) begin
				fatal_mask_q <= pwdata;
			end else if (paddr == OFS_HIST_IDX) begin
				hist_idx_q <= pwdata[HAW-1:0];
			end
		end
	end

	// ----------------------------------------
	// apb read
	// ----------------------------------------
	always_comb begin
		rd_mux = 32'h00000000;
		rd_err = 1'b0;
		if (paddr == OFS_CTRL) begin
			rd_mux = {28'h0, alm_cfg_q, 1'b0, host_en_q, ~host_en_q};
		end else if (paddr == OFS_STATUS) begin
			rd_mux = {27'h0, |fault_latch_q, fatal_q, remote_enable,
				~fatal_q & ~|fault_latch_q & ~|fault_cond, drive_en_q};
		end else if (paddr == OFS_FAULT_LATCH) begin
			rd_mux = fault_latch_q;
		end else if (paddr == OFS_WARN_LO) begin
			rd_mux = warn_q[31:0];
		end else if (paddr == OFS_WARN_HI) begin
			rd_mux = warn_q[63:32];
		end else if (paddr == OFS_HIST_IDX) begin
			rd_mux = {hist_total, 8'(hist_wptr), 8'(hist_idx_q)};
		end else if (paddr == OFS_HIST_DATA) begin
			rd_mux = {24'h0, hist_rd};
		end else if (paddr == OFS_IRQ_STAT) begin
			rd_mux = {29'h0, irq_stat_q};
		end else if (paddr == OFS_IRQ_MASK) begin
			rd_mux = {29'h0, irq_mask_q};
		end else if (paddr == OFS_DISP_MASK) begin
			rd_mux = disp_mask_q;
		end else if (paddr == OFS_FATAL_MASK) begin
			rd_mux = fatal_mask_q;
		end else begin
			rd_err = 1'b1;
		end
	end

	// read data registered in the setup cycle, valid during access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			prdata_q <= rd_mux;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_q <= 1'b0;
		end else if (psel && !penable) begin
			err_q <= rd_err && !(pwrite && paddr == OFS_CTRL);
		end
	end

	assign prdata = prdata_q;
	assign pready = 1'b1;
	assign pslverr = err_q;
	assign drive_enable = drive_en_q;
	assign display_code = disp_q;
	assign irq = irq_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_fault_drops_enable: assert property (@(posedge pclk) disable iff (!presetn)
		|fault_cond |=> !drive_enable) else $error("drive enabled with fault present");
	a_latch_blocks_enable: assert property (@(posedge pclk) disable iff (!presetn)
		|fault_latch_q |=> !drive_enable) else $error("drive enabled with latched fault");
	a_clear_keeps_active: assert property (@(posedge pclk) disable iff (!presetn)
		clear_req |=> (fault_latch_q & $past(fault_cond)) == $past(fault_cond)) else $error("active fault cleared");
	a_clear_drops_idle: assert property (@(posedge pclk) disable iff (!presetn)
		clear_req |=> (fault_latch_q & ~$past(fault_cond)) == '0) else $error("idle fault not cleared");
	a_warn_tracks: assert property (@(posedge pclk) disable iff (!presetn)
		!warn_cond[0] |=> !warn_q[0]) else $error("warning not released");
	a_fatal_sticks: assert property (@(posedge pclk) disable iff (!presetn)
		fatal_q |=> fatal_q && !drive_enable) else $error("fatal state released");
	a_reenable: assert property (@(posedge pclk) disable iff (!presetn)
		!fatal_q && fault_latch_q == '0 && fault_cond == '0 && host_en_q && remote_enable
		|=> drive_enable) else $error("drive not reenabled");
	a_cmd_lost: assert property (@(posedge pclk) disable iff (!presetn)
		(cmd_update && !cmd_received)[*3] |=> warn_now[CMD_LOST_WARN]) else $error("command lost missed");
endmodule

// ---- verification/apb_host.sv ----
// Purpose: apb master standing for the host side of the fault block
// Assumes: slave raises pready in some access cycle
// Notes: an access not answered within 16 access edges is counted in stall_count
`timescale 1ns/10ps
module apb_host (
	// clock
	input wire logic pclk,
	// request
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	// answer
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	int stall_count = 0;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
	end
	// request held until pready is seen high at an access edge
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			stall_count++;
			testbench.tally_and_finish();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule

// ---- verification/testbench.sv ----
// Purpose: self-checking bench for the drive fault supervision block
// Assumes: host side played by apb_host, conditions driven here
// Notes: fatal fault case runs last and is undone by a reset
`timescale 1ns/10ps
module testbench;
	import fault_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr, display_code;
	logic [31:0] pwdata, prdata, r, h, g, x;
	logic [31:0] fault_cond;
	logic [63:0] warn_cond;
	logic cmd_update, cmd_received, remote_enable, alarm_clear_in, drive_enable, irq, e;
	int err_count = 0;
	int check_count = 0;
	int f, i, j;
	drive_fault_latch_control dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fault_cond(fault_cond), .warn_cond(warn_cond), .cmd_update(cmd_update),
		.cmd_received(cmd_received), .remote_enable(remote_enable), .alarm_clear_in(alarm_clear_in),
		.drive_enable(drive_enable), .display_code(display_code), .irq(irq));
	apb_host apb_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH time=%0t got=%h expected=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic s;
		apb_u.xfer(1'b1, a, d, q, s);
	endtask
	task rd(input logic [7:0] a, output logic [31:0] q);
		logic s;
		apb_u.xfer(1'b0, a, 32'h00000000, q, s);
		chk(s, 1'b0);
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		rd(a, q);
		chk(q, exp);
	endtask
	task wait_en(input logic exp);
		int n;
		n = 0;
		while (drive_enable !== exp && n < 16) begin
			cyc(1);
			n++;
		end
		chk(drive_enable, exp);
		if (drive_enable !== exp)
			tally_and_finish();
	endtask
	task upd(input logic rx);
		cmd_received <= rx;
		cmd_update <= 1'b1;
		cyc(1);
		cmd_update <= 1'b0;
		cyc(1);
	endtask
	task toggle_alarm();
		alarm_clear_in <= 1'b0;
		cyc(3);
		alarm_clear_in <= 1'b1;
		cyc(1);
	endtask
	task do_reset();
		presetn <= 1'b0;
		cyc(10);
		presetn <= 1'b1;
		cyc(1);
	endtask
	// lt is the latch content expected while the source is low
	task clear_by(input int m, input logic [31:0] lt);
		case (m)
			0: begin
				wr(OFS_CTRL, 32'h1 << CTRL_DISABLE);
				wr(OFS_CTRL, 32'h1 << CTRL_ENABLE);
			end
			1: begin
				remote_enable <= 1'b0;
				cyc(3);
				rd(OFS_STATUS, r);
				chk(r[ST_REMOTE], 1'b0);
				rdc(OFS_FAULT_LATCH, lt);
				remote_enable <= 1'b1;
				cyc(1);
			end
			2: begin
				wr(OFS_CTRL, 32'h1 << CTRL_ALM_CFG);
				toggle_alarm();
			end
			default: wr(OFS_CTRL, 32'h1 << CTRL_CLEAR_ALL);
		endcase
	endtask
	task tally_and_finish();
		err_count += apb_u.stall_count;
		$display("checks=%0d mismatches=%0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		presetn = 1'b0;
		fault_cond = '0;
		warn_cond = '0;
		cmd_update = 1'b0;
		cmd_received = 1'b0;
		remote_enable = 1'b1;
		alarm_clear_in = 1'b1;
		void'($urandom(16393));
		do_reset();
		cyc(3);
		rd(OFS_STATUS, r);
		chk(r[4:0], 5'b00111);
		rdc(OFS_DISP_MASK, DISP_MASK_RST);
		rdc(OFS_FATAL_MASK, FATAL_MASK_RST);
		rdc(OFS_FAULT_LATCH, 32'h0);
		chk(display_code, DISP_BLANK);
		apb_u.xfer(1'b0, 8'h30, 32'h0, r, e);
		chk(r, 32'h0);
		chk(e, 1'b1);
		$display("test reset_and_map done");
		wr(OFS_IRQ_MASK, 32'h1 << IRQ_FAULT);
		for (int k = 0; k < 3; k++) begin
			i = $urandom_range(31);
			j = $urandom_range(47, 32);
			warn_cond <= (64'h1 << i) | (64'h1 << j);
			cyc(3);
			chk(drive_enable, 1'b1);
			chk(display_code, DISP_WARN_BASE | i);
			rdc(OFS_WARN_LO, 32'h1 << i);
			rdc(OFS_WARN_HI, 32'h1 << (j - 32));
			rd(OFS_IRQ_STAT, r);
			chk(r[IRQ_WARN], 1'b1);
			chk(irq, 1'b0);
			warn_cond <= '0;
			cyc(3);
			rdc(OFS_WARN_LO, 32'h0);
			chk(display_code, DISP_BLANK);
			wr(OFS_IRQ_STAT, 32'h1 << IRQ_WARN);
			rdc(OFS_IRQ_STAT, 32'h0);
		end
		$display("test warnings done");
		repeat (CMD_LOST_COUNT - 1) upd(1'b0);
		upd(1'b1);
		repeat (CMD_LOST_COUNT - 1) upd(1'b0);
		rdc(OFS_WARN_HI, 32'h0);
		upd(1'b0);
		rdc(OFS_WARN_HI, 32'h1 << (CMD_LOST_WARN - 32));
		upd(1'b1);
		rdc(OFS_WARN_HI, 32'h0);
		cmd_received <= 1'b0;
		cmd_update <= 1'b1;
		cyc(3);
		cmd_update <= 1'b0;
		cyc(1);
		rdc(OFS_WARN_HI, 32'h1 << (CMD_LOST_WARN - 32));
		upd(1'b1);
		rdc(OFS_WARN_HI, 32'h0);
		wr(OFS_IRQ_STAT, 32'hFFFFFFFF);
		$display("test command_lost done");
		for (int m = 0; m < 4; m++) begin
			f = $urandom_range(31);
			x = 32'h1 << f;
			rd(OFS_HIST_IDX, h);
			fault_cond[f] <= 1'b1;
			cyc(3);
			chk(drive_enable, 1'b0);
			chk(display_code, DISP_FAULT_BASE | f);
			chk(irq, 1'b1);
			clear_by(m, x);
			cyc(3);
			rdc(OFS_FAULT_LATCH, x);
			fault_cond <= '0;
			cyc(3);
			chk(drive_enable, 1'b0);
			rdc(OFS_FAULT_LATCH, x);
			rd(OFS_STATUS, r);
			chk(r[4:0], 5'b10100);
			if (m == 1) begin
				toggle_alarm();
				rdc(OFS_FAULT_LATCH, x);
			end
			clear_by(m, x);
			wait_en(1'b1);
			rdc(OFS_FAULT_LATCH, 32'h0);
			rd(OFS_HIST_IDX, g);
			chk(g[31:16], h[31:16] + 16'h0001);
			wr(OFS_HIST_IDX, {24'h0, h[15:8]});
			rdc(OFS_HIST_DATA, f);
			wr(OFS_IRQ_STAT, 32'hFFFFFFFF);
			cyc(2);
			chk(irq, 1'b0);
		end
		$display("test fault_clear done");
		f = $urandom_range(31);
		wr(OFS_FATAL_MASK, 32'h1 << f);
		fault_cond[f] <= 1'b1;
		cyc(3);
		fault_cond <= '0;
		clear_by(3, 32'h0);
		clear_by(0, 32'h0);
		cyc(8);
		chk(drive_enable, 1'b0);
		rd(OFS_STATUS, r);
		chk(r[4:0], 5'b01100);
		do_reset();
		wait_en(1'b1);
		$display("test fatal done");
		tally_and_finish();
	end
endmodule
